//--- include/lsdgc_pkg.sv
// Constants for the sync-gate, delay-loop and coarse-gain input block.
// Assumes a reference-clock core domain and a free-running link data clock.
// Overview of operation
// - Sync low: ignore buffered data and feed zero-amplitude samples instead.
// - Sync rising edge fires one sync event, shaped by two config words.
// - Sync bit is captured into the input buffer together with the data.
// - Selected software sync replaces the pin; it is asynchronous to us.
// - Delay loop skews the data clock against data and sync bits.
// - Writing the restart bit starts the delay loop; host does it after range.
// - Lock status bit reports delay-loop lock after initialisation.
// - Each channel has its own 4-bit coarse gain field in one register.
// - Full-scale multiple per channel equals gain code plus one.
// - Gain fields reset to maximum, giving sixteen times bias current.
// - Samples are offset binary; complement output is the bitwise inverse of passed codes, mid code when gated.
// - Samples are captured on both edges of the half-rate data clock.
// - Delay-loop config holds frequency-range and skew-offset settings.
package lsdgc_pkg;
	localparam int DATA_W = 16;
	localparam int WORD_W = 17; // Data plus sync bit
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int IFIXED_W = 3;
	localparam int DELAY_W = 4;
	localparam int GAIN_W = 4;
	localparam int MULT_W = 5;
	localparam int CFG_W = 8;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 4'hf;
	localparam logic [IFIXED_W-1:0] IFIXED_RESET = 3'h0;
	localparam logic [DELAY_W-1:0] DELAY_RESET = 4'h0;
	localparam logic [DATA_W-1:0] MID_CODE = 16'h8000; // Zero amplitude offset binary
	localparam int LOCK_COUNT = 16; // Stable link edges seen before lock
	localparam int LOCK_W = 5;
	localparam int PHASE_W = 4;
	typedef enum logic [1:0] {LSDGC_IDLE, LSDGC_ACQUIRE, LSDGC_LOCKED} lsdgc_loop_t;
endpackage : lsdgc_pkg

//--- src/lsdgc_link_capture.sv
// Link-side capture: DDR samples plus sync bit into a gray-pointer buffer.
// Assumes the data clock runs free and data arrives aligned to both edges.
`timescale 1ns/100ps
module lsdgc_link_capture (
	input wire logic i_link_clk,
	input wire logic i_link_rst,
	input wire logic [lsdgc_pkg::DATA_W-1:0] i_data,
	input wire logic i_sync,
	input wire logic [lsdgc_pkg::DELAY_W-1:0] i_delay,
	input wire logic [lsdgc_pkg::PTR_W:0] i_rd_gray,
	output logic [lsdgc_pkg::PTR_W:0] o_wr_gray,
	output logic [lsdgc_pkg::WORD_W-1:0] o_mem [lsdgc_pkg::FIFO_DEPTH]
);
	logic [lsdgc_pkg::WORD_W-1:0] rise_reg;
	logic [lsdgc_pkg::WORD_W-1:0] fall_reg;
	logic [lsdgc_pkg::PTR_W:0] wr_bin_reg;
	logic [lsdgc_pkg::PHASE_W-1:0] skew_reg;
	logic [lsdgc_pkg::DELAY_W-1:0] delay_s1_reg;
	logic [lsdgc_pkg::DELAY_W-1:0] delay_s2_reg;
	logic [lsdgc_pkg::PTR_W:0] rd_gray_s1_reg;
	logic [lsdgc_pkg::PTR_W:0] rd_gray_s2_reg;
	logic [lsdgc_pkg::PTR_W:0] rd_bin;
	logic [lsdgc_pkg::PTR_W:0] wr_bin_next;
	logic [lsdgc_pkg::PTR_W-1:0] pair_next;
	logic [lsdgc_pkg::PTR_W:0] used;
	logic room;

	// Core-side read pointer and delay setting cross through two flops;
	// delay is quasi-static, a change is followed by a loop restart anyway
	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			delay_s1_reg <= '0;
			delay_s2_reg <= '0;
			rd_gray_s1_reg <= '0;
			rd_gray_s2_reg <= '0;
		end else begin
			delay_s1_reg <= i_delay;
			delay_s2_reg <= delay_s1_reg;
			rd_gray_s1_reg <= i_rd_gray;
			rd_gray_s2_reg <= rd_gray_s1_reg;
		end
	end

	// Read pointer back to binary, one bit per generate step
	assign rd_bin[lsdgc_pkg::PTR_W] = rd_gray_s2_reg[lsdgc_pkg::PTR_W];
	for (genvar b = 0; b < lsdgc_pkg::PTR_W; b++) begin : g_rd_bin
		assign rd_bin[b] = rd_bin[b+1] ^ rd_gray_s2_reg[b];
	end

	// Room for a whole pair; stale read pointer only makes this cautious
	assign wr_bin_next = wr_bin_reg + 4'h2;
	assign pair_next = wr_bin_next[lsdgc_pkg::PTR_W:1];
	assign used = wr_bin_reg - rd_bin;
	assign room = (used <= (lsdgc_pkg::PTR_W + 1)'(lsdgc_pkg::FIFO_DEPTH - 2));

	// Falling-edge half of the DDR capture
	always_ff @(negedge i_link_clk) begin
		fall_reg <= {i_sync, i_data};
	end

	// Rising-edge half; skew register models the delay setting
	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			rise_reg <= '0;
			skew_reg <= '0;
		end else begin
			rise_reg <= {i_sync, i_data};
			skew_reg <= delay_s2_reg;
		end
	end

	// Two words per clock period, written as a pair only when both fit;
	// a slow reader loses whole pairs, never half of one
	always_ff @(posedge i_link_clk) begin
		if (i_link_rst) begin
			wr_bin_reg <= '0;
			o_wr_gray <= '0;
		end else if (room) begin
			o_mem[wr_bin_reg[lsdgc_pkg::PTR_W-1:0]] <= rise_reg;
			o_mem[lsdgc_pkg::PTR_W'(wr_bin_reg[lsdgc_pkg::PTR_W-1:0] + 1'b1)] <= fall_reg;
			wr_bin_reg <= wr_bin_next;
			o_wr_gray <= {pair_next ^ (pair_next >> 1), 1'b0}; // Pair units, one bit moves
		end
	end
endmodule : lsdgc_link_capture

//--- src/lsdgc_top.sv
// Sync gate, delay-loop control and coarse gain for the wideband input.
// Assumes a core reference clock and a separate link data clock from the source.
`timescale 1ns/100ps
module lsdgc_top (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_half_rate_data_clock,
	input wire logic i_link_reset,
	input wire logic [lsdgc_pkg::DATA_W-1:0] i_data,
	input wire logic i_sync_gate_pair,
	input wire logic i_soft_sync_sel,
	input wire logic i_soft_sync,
	input wire logic [lsdgc_pkg::CFG_W-1:0] i_sync_behavior_cfg_a,
	input wire logic [lsdgc_pkg::CFG_W-1:0] i_sync_behavior_cfg_b,
	input wire logic [lsdgc_pkg::GAIN_W-1:0] i_chan_a_coarse_gain,
	input wire logic [lsdgc_pkg::GAIN_W-1:0] i_chan_b_coarse_gain,
	input wire logic i_gain_load,
	input wire logic i_loop_restart,
	input wire logic [lsdgc_pkg::IFIXED_W-1:0] i_loop_ifixed,
	input wire logic [lsdgc_pkg::DELAY_W-1:0] i_loop_delay,
	input wire logic i_loop_cfg_load,
	output logic [lsdgc_pkg::DATA_W-1:0] o_sample,
	output logic [lsdgc_pkg::DATA_W-1:0] o_sample_true,
	output logic o_sample_valid,
	output logic o_transmit_gate,
	output logic o_sync_event,
	output logic [lsdgc_pkg::CFG_W-1:0] o_sync_actions,
	output logic [lsdgc_pkg::MULT_W-1:0] o_chan_a_fs_mult,
	output logic [lsdgc_pkg::MULT_W-1:0] o_chan_b_fs_mult,
	output logic [lsdgc_pkg::GAIN_W-1:0] o_chan_a_coarse_gain,
	output logic [lsdgc_pkg::GAIN_W-1:0] o_chan_b_coarse_gain,
	output logic [lsdgc_pkg::IFIXED_W-1:0] o_loop_ifixed,
	output logic [lsdgc_pkg::DELAY_W-1:0] o_loop_delay,
	output logic o_loop_lock
);
	logic [lsdgc_pkg::PTR_W:0] wr_gray;
	logic [lsdgc_pkg::WORD_W-1:0] mem [lsdgc_pkg::FIFO_DEPTH];
	logic [lsdgc_pkg::PTR_W:0] wr_gray_s1_reg;
	logic [lsdgc_pkg::PTR_W:0] wr_gray_s2_reg;
	logic [lsdgc_pkg::PTR_W:0] wr_bin;
	logic [lsdgc_pkg::PTR_W:0] rd_bin_reg;
	logic [lsdgc_pkg::PTR_W:0] rd_bin_next;
	logic [lsdgc_pkg::PTR_W:0] rd_gray_reg;
	logic fifo_empty;
	logic [lsdgc_pkg::WORD_W-1:0] head_word;
	logic word_sync;
	logic soft_s1_reg;
	logic soft_s2_reg;
	logic sel_s1_reg;
	logic sel_s2_reg;
	logic sync_level;
	logic sync_prev_reg;
	logic [lsdgc_pkg::DELAY_W-1:0] delay_reg;
	logic restart_prev_reg;
	logic restart_pulse;
	logic link_toggle_reg;
	logic link_div_reg;
	logic tog_s1_reg;
	logic tog_s2_reg;
	logic tog_s3_reg;
	logic link_edge;
	logic [lsdgc_pkg::LOCK_W-1:0] lock_cnt_reg;
	logic [3:0] idle_cnt_reg;
	lsdgc_pkg::lsdgc_loop_t loop_state_reg;
	lsdgc_pkg::lsdgc_loop_t loop_state_next;

	// Link-side capture and buffer writer
	lsdgc_link_capture u_capture (
		.i_link_clk(i_half_rate_data_clock),
		.i_link_rst(i_link_reset),
		.i_data(i_data),
		.i_sync(i_sync_gate_pair),
		.i_delay(delay_reg),
		.i_rd_gray(rd_gray_reg),
		.o_wr_gray(wr_gray),
		.o_mem(mem)
	);

	// Heartbeat in the link domain; toggles every second edge so that
	// the slower core clock cannot alias the changes away
	always_ff @(posedge i_half_rate_data_clock) begin
		if (i_link_reset) begin
			link_div_reg <= 1'b0;
			link_toggle_reg <= 1'b0;
		end else begin
			link_div_reg <= ~link_div_reg;
			if (link_div_reg) begin
				link_toggle_reg <= ~link_toggle_reg;
			end
		end
	end

	// Write pointer crosses as gray code through two flops
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			wr_gray_s1_reg <= '0;
			wr_gray_s2_reg <= '0;
		end else begin
			wr_gray_s1_reg <= wr_gray;
			wr_gray_s2_reg <= wr_gray_s1_reg;
		end
	end

	// Gray to binary in pair units; the word bit of the write pointer stays zero
	assign wr_bin[lsdgc_pkg::PTR_W] = wr_gray_s2_reg[lsdgc_pkg::PTR_W];
	for (genvar b = 1; b < lsdgc_pkg::PTR_W; b++) begin : g_gray
		assign wr_bin[b] = wr_bin[b+1] ^ wr_gray_s2_reg[b];
	end
	assign wr_bin[0] = wr_gray_s2_reg[0];

	// Empty when the crossed write pointer meets the read pointer
	assign fifo_empty = (wr_bin == rd_bin_reg);
	assign head_word = mem[rd_bin_reg[lsdgc_pkg::PTR_W-1:0]];
	assign word_sync = head_word[lsdgc_pkg::DATA_W];

	// Software sync bits come from another domain, so synchronise them
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			soft_s1_reg <= 1'b0;
			soft_s2_reg <= 1'b0;
			sel_s1_reg <= 1'b0;
			sel_s2_reg <= 1'b0;
		end else begin
			soft_s1_reg <= i_soft_sync;
			soft_s2_reg <= soft_s1_reg;
			sel_s1_reg <= i_soft_sync_sel;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	// Selected source of the sync level; buffered bit keeps data alignment
	always_comb begin
		if (sel_s2_reg) begin
			sync_level = soft_s2_reg;
		end else if (!fifo_empty) begin
			sync_level = word_sync;
		end else begin
			sync_level = sync_prev_reg;
		end
	end

	// Buffer read: one word per core cycle while data is waiting
	assign rd_bin_next = rd_bin_reg + 4'h1;
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rd_bin_reg <= '0;
		end else if (!fifo_empty) begin
			rd_bin_reg <= rd_bin_next;
		end
	end

	// Read pointer published to the link side as gray, for its room check
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rd_gray_reg <= '0;
		end else if (!fifo_empty) begin
			rd_gray_reg <= rd_bin_next ^ (rd_bin_next >> 1);
		end
	end

	// Sample path; zero amplitude replaces data while the gate is low
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_sample <= lsdgc_pkg::MID_CODE;
			o_sample_true <= lsdgc_pkg::MID_CODE;
			o_sample_valid <= 1'b0;
			o_transmit_gate <= 1'b0;
		end else begin
			o_transmit_gate <= sync_level;
			o_sample_valid <= !fifo_empty;
			if (!fifo_empty && sync_level) begin
				o_sample <= head_word[lsdgc_pkg::DATA_W-1:0];
				o_sample_true <= ~head_word[lsdgc_pkg::DATA_W-1:0];
			end else begin
				o_sample <= lsdgc_pkg::MID_CODE;
				o_sample_true <= lsdgc_pkg::MID_CODE;
			end
		end
	end

	// Rising edge of the sync level fires one event with the action mask
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			sync_prev_reg <= 1'b0;
			o_sync_event <= 1'b0;
			o_sync_actions <= '0;
		end else begin
			sync_prev_reg <= sync_level;
			o_sync_event <= sync_level && !sync_prev_reg;
			if (sync_level && !sync_prev_reg) begin
				o_sync_actions <= i_sync_behavior_cfg_a | i_sync_behavior_cfg_b;
			end
		end
	end

	// Coarse gain per channel; reset to maximum code
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_chan_a_coarse_gain <= lsdgc_pkg::GAIN_RESET;
			o_chan_b_coarse_gain <= lsdgc_pkg::GAIN_RESET;
			o_chan_a_fs_mult <= {1'b0, lsdgc_pkg::GAIN_RESET} + 5'h01;
			o_chan_b_fs_mult <= {1'b0, lsdgc_pkg::GAIN_RESET} + 5'h01;
		end else if (i_gain_load) begin
			o_chan_a_coarse_gain <= i_chan_a_coarse_gain;
			o_chan_b_coarse_gain <= i_chan_b_coarse_gain;
			o_chan_a_fs_mult <= {1'b0, i_chan_a_coarse_gain} + 5'h01;
			o_chan_b_fs_mult <= {1'b0, i_chan_b_coarse_gain} + 5'h01;
		end
	end

	// Delay-loop settings: frequency range and skew offset
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_loop_ifixed <= lsdgc_pkg::IFIXED_RESET;
			o_loop_delay <= lsdgc_pkg::DELAY_RESET;
			delay_reg <= lsdgc_pkg::DELAY_RESET;
		end else if (i_loop_cfg_load) begin
			o_loop_ifixed <= i_loop_ifixed;
			o_loop_delay <= i_loop_delay;
			delay_reg <= i_loop_delay;
		end
	end

	// Heartbeat crossing; the third flop feeds the edge detector only
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
			restart_prev_reg <= 1'b0;
		end else begin
			tog_s1_reg <= link_toggle_reg;
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
			restart_prev_reg <= i_loop_restart;
		end
	end

	// Heartbeat change and restart rise, both in the core domain
	assign link_edge = tog_s2_reg ^ tog_s3_reg;
	assign restart_pulse = i_loop_restart && !restart_prev_reg;

	// Missing-clock watchdog; lock cannot hold without a steady clock
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || link_edge) begin
			idle_cnt_reg <= 4'h0;
		end else if (idle_cnt_reg != 4'hf) begin
			idle_cnt_reg <= idle_cnt_reg + 4'h1;
		end
	end

	// Loop state machine
	always_comb begin
		loop_state_next = loop_state_reg;
		case (loop_state_reg)
			lsdgc_pkg::LSDGC_IDLE: begin
				if (restart_pulse) begin
					loop_state_next = lsdgc_pkg::LSDGC_ACQUIRE;
				end
			end
			lsdgc_pkg::LSDGC_ACQUIRE: begin
				if (restart_pulse) begin
					loop_state_next = lsdgc_pkg::LSDGC_ACQUIRE;
				end else if (lock_cnt_reg == lsdgc_pkg::LOCK_W'(lsdgc_pkg::LOCK_COUNT)) begin
					loop_state_next = lsdgc_pkg::LSDGC_LOCKED;
				end
			end
			lsdgc_pkg::LSDGC_LOCKED: begin
				if (restart_pulse || idle_cnt_reg == 4'hf) begin
					loop_state_next = lsdgc_pkg::LSDGC_ACQUIRE;
				end
			end
			default: begin
				loop_state_next = lsdgc_pkg::LSDGC_IDLE;
			end
		endcase
	end

	// State register and acquisition counter
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			loop_state_reg <= lsdgc_pkg::LSDGC_IDLE;
			lock_cnt_reg <= '0;
		end else begin
			loop_state_reg <= loop_state_next;
			if (restart_pulse || loop_state_reg != lsdgc_pkg::LSDGC_ACQUIRE
				|| idle_cnt_reg == 4'hf) begin
				lock_cnt_reg <= '0;
			end else if (link_edge) begin
				lock_cnt_reg <= lock_cnt_reg + 5'h01;
			end
		end
	end

	// Lock status flop; restart clears it at once
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_loop_lock <= 1'b0;
		end else begin
			o_loop_lock <= (loop_state_next == lsdgc_pkg::LSDGC_LOCKED) && !restart_pulse;
		end
	end
endmodule : lsdgc_top

//--- verification/lsdgc_top_sva.sv
// Core-domain checker for the sync gate, gain and delay-loop outputs.
// Assumes binding onto lsdgc_top and its core clock and reset.
`timescale 1ns/100ps
module lsdgc_top_sva (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_sync_behavior_cfg_a,
	input wire logic [7:0] i_sync_behavior_cfg_b,
	input wire logic [3:0] i_chan_a_coarse_gain,
	input wire logic [3:0] i_chan_b_coarse_gain,
	input wire logic i_gain_load,
	input wire logic i_loop_restart,
	input wire logic [2:0] i_loop_ifixed,
	input wire logic [3:0] i_loop_delay,
	input wire logic i_loop_cfg_load,
	input wire logic [15:0] o_sample,
	input wire logic [15:0] o_sample_true,
	input wire logic o_sample_valid,
	input wire logic o_transmit_gate,
	input wire logic o_sync_event,
	input wire logic [7:0] o_sync_actions,
	input wire logic [4:0] o_chan_a_fs_mult,
	input wire logic [4:0] o_chan_b_fs_mult,
	input wire logic [3:0] o_chan_a_coarse_gain,
	input wire logic [3:0] o_chan_b_coarse_gain,
	input wire logic [2:0] o_loop_ifixed,
	input wire logic [3:0] o_loop_delay,
	input wire logic o_loop_lock
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// Restart edge, then lock must come back within a bounded span
	sequence s_restart;
		$rose(i_loop_restart);
	endsequence
	sequence s_relock;
		##[10:60] o_loop_lock;
	endsequence
	a_gate_zero_out: assert property (
		!o_transmit_gate |-> o_sample == lsdgc_pkg::MID_CODE && o_sample_true == lsdgc_pkg::MID_CODE)
		else $error("gated sample not mid code");
	a_offset_code_pair: assert property (
		o_sample_valid && o_transmit_gate |-> o_sample_true == ~o_sample)
		else $error("true output not complement of code");
	a_event_one_cycle: assert property (
		o_sync_event |=> !o_sync_event)
		else $error("sync event longer than one cycle");
	a_actions_on_event: assert property (
		o_sync_event |=> o_sync_actions == (i_sync_behavior_cfg_a | i_sync_behavior_cfg_b))
		else $error("sync actions not taken from config");
	a_actions_only_event: assert property (
		!$stable(o_sync_actions) |-> o_sync_event || $past(o_sync_event))
		else $error("sync actions changed without event");
	a_mult_is_gain: assert property (
		!i_gain_load && !$past(i_gain_load) |-> o_chan_a_fs_mult == o_chan_a_coarse_gain + 5'h01
		&& o_chan_b_fs_mult == o_chan_b_coarse_gain + 5'h01) else $error("multiple not gain plus one");
	a_gain_load_take: assert property (
		i_gain_load |=> o_chan_a_coarse_gain == $past(i_chan_a_coarse_gain)
		&& o_chan_b_coarse_gain == $past(i_chan_b_coarse_gain)) else $error("gain not loaded");
	a_gain_held: assert property (
		!i_gain_load |=> $stable(o_chan_a_coarse_gain) && $stable(o_chan_b_coarse_gain))
		else $error("gain changed without load");
	a_cfg_load_take: assert property (
		i_loop_cfg_load |=> o_loop_ifixed == $past(i_loop_ifixed) && o_loop_delay == $past(i_loop_delay))
		else $error("loop settings not loaded");
	a_restart_drops_lock: assert property (
		s_restart |=> !o_loop_lock [*8]) else $error("lock not cleared by restart");
	a_relock_bounded: assert property (
		s_restart |-> s_relock) else $error("lock not regained");
endmodule : lsdgc_top_sva
bind lsdgc_top lsdgc_top_sva u_sva (.i_ref_clk, .i_reset, .i_sync_behavior_cfg_a,
	.i_sync_behavior_cfg_b, .i_chan_a_coarse_gain, .i_chan_b_coarse_gain, .i_gain_load,
	.i_loop_restart, .i_loop_ifixed, .i_loop_delay, .i_loop_cfg_load, .o_sample, .o_sample_true,
	.o_sample_valid, .o_transmit_gate, .o_sync_event, .o_sync_actions, .o_chan_a_fs_mult,
	.o_chan_b_fs_mult, .o_chan_a_coarse_gain, .o_chan_b_coarse_gain, .o_loop_ifixed,
	.o_loop_delay, .o_loop_lock);

//--- verification/lsdgc_src_model.sv
// Link source model: free-running half-rate clock, DDR words and sync bit.
// Assumes the receiver captures on both clock edges.
`timescale 1ns/100ps
module lsdgc_src_model (
	output logic o_link_clk,
	output logic [15:0] o_data,
	output logic o_sync
);
	// Clock never pauses, the delay loop needs it steady to hold lock
	initial begin
		o_link_clk = 1'b0;
		o_data = 16'hffff;
		o_sync = 1'b0;
		forever #40 o_link_clk = ~o_link_clk;
	end
	// Words change mid half-period; rise word first, sync beside its word
	task automatic send(input logic [15:0] w0, input logic [15:0] w1, input logic s, input int n);
		repeat (n) begin
			@(negedge o_link_clk) #20;
			o_data = w0;
			o_sync = s;
			@(posedge o_link_clk) #20;
			o_data = w1;
		end
		@(negedge o_link_clk) #20;
		o_data = ~w1;
		o_sync = 1'b0;
	endtask : send
endmodule : lsdgc_src_model

//--- verification/lsdgc_tb_top.sv
// Self-checking bench for the sync gate, gain and delay-loop block.
// Assumes lsdgc_top, its bound checker and the link source model.
`timescale 1ns/100ps
module lsdgc_tb_top;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_link_reset = 1'b1;
	logic i_soft_sync_sel = 1'b0;
	logic i_soft_sync = 1'b0;
	logic i_gain_load = 1'b0;
	logic i_loop_restart = 1'b0;
	logic i_loop_cfg_load = 1'b0;
	logic [7:0] i_sync_behavior_cfg_a = 8'h21;
	logic [7:0] i_sync_behavior_cfg_b = 8'h84;
	logic [3:0] i_chan_a_coarse_gain = 4'h0;
	logic [3:0] i_chan_b_coarse_gain = 4'h0;
	logic [2:0] i_loop_ifixed = 3'h0;
	logic [3:0] i_loop_delay = 4'h0;
	wire logic lclk;
	wire logic lsync;
	wire logic [15:0] ldata;
	wire logic [15:0] o_sample;
	wire logic [15:0] o_sample_true;
	wire logic [7:0] o_sync_actions;
	wire logic [4:0] o_chan_a_fs_mult;
	wire logic [4:0] o_chan_b_fs_mult;
	wire logic [3:0] o_chan_a_coarse_gain;
	wire logic [3:0] o_chan_b_coarse_gain;
	wire logic [3:0] o_loop_delay;
	wire logic [2:0] o_loop_ifixed;
	wire logic o_sample_valid;
	wire logic o_transmit_gate;
	wire logic o_sync_event;
	wire logic o_loop_lock;
	int bad_count = 0;
	int tests_run = 0;
	int ev = 0;
	logic [15:0] last;
	logic [15:0] prev;
	lsdgc_src_model src (.o_link_clk(lclk), .o_data(ldata), .o_sync(lsync));
	lsdgc_top dut (.i_ref_clk, .i_reset, .i_half_rate_data_clock(lclk), .i_link_reset,
		.i_data(ldata), .i_sync_gate_pair(lsync), .i_soft_sync_sel, .i_soft_sync,
		.i_sync_behavior_cfg_a, .i_sync_behavior_cfg_b, .i_chan_a_coarse_gain,
		.i_chan_b_coarse_gain, .i_gain_load, .i_loop_restart, .i_loop_ifixed, .i_loop_delay,
		.i_loop_cfg_load, .o_sample, .o_sample_true, .o_sample_valid, .o_transmit_gate,
		.o_sync_event, .o_sync_actions, .o_chan_a_fs_mult, .o_chan_b_fs_mult,
		.o_chan_a_coarse_gain, .o_chan_b_coarse_gain, .o_loop_ifixed, .o_loop_delay, .o_loop_lock);
	// Core clock, 100 ns period
	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// Count events and keep the last two passed samples for order checks
	always @(posedge i_ref_clk) begin
		if (o_sync_event === 1'b1) ev <= ev + 1;
		if (o_sample_valid === 1'b1 && o_transmit_gate === 1'b1) begin
			prev <= last;
			last <= o_sample;
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : cyc
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	// Pin sync held low must gate out live data
	task automatic t_gated;
		src.send(16'h1234, 16'h4321, 1'b0, 3);
		cyc(10);
		chk(o_transmit_gate === 1'b0 && o_sample === 16'h8000, "gated output");
	endtask : t_gated
	// Sync high for eight link periods; the buffer drops only whole pairs,
	// so passed words keep rise-then-fall order and one event fires
	task automatic t_pass;
		int e;
		e = ev;
		src.send(16'ha5c3, 16'h0f96, 1'b1, 8);
		cyc(20);
		chk(prev === 16'ha5c3 && last === 16'h0f96, "ddr word order");
		chk(ev === e + 1, "event count");
		chk(o_sync_actions === 8'ha5, "sync actions");
	endtask : t_pass
	// Software sync overrides a low pin and fires the event
	task automatic t_soft;
		int e;
		e = ev;
		i_soft_sync_sel <= 1'b1;
		cyc(5);
		chk(o_transmit_gate === 1'b0, "soft sync low");
		i_soft_sync <= 1'b1;
		cyc(6);
		chk(o_transmit_gate === 1'b1 && ev === e + 1, "soft sync event");
		i_soft_sync <= 1'b0;
		i_soft_sync_sel <= 1'b0;
		cyc(6);
	endtask : t_soft
	// Every gain code on both channels, then an unloaded change
	task automatic t_gain;
		for (int i = 0; i < 16; i++) begin
			i_chan_a_coarse_gain <= i[3:0];
			i_chan_b_coarse_gain <= 4'hf - i[3:0];
			i_gain_load <= 1'b1;
			cyc(1);
			i_gain_load <= 1'b0;
			cyc(2);
			chk(o_chan_a_fs_mult === 5'(i + 1) && o_chan_b_fs_mult === 5'(16 - i), "gain");
		end
		i_chan_a_coarse_gain <= 4'h3;
		cyc(3);
		chk(o_chan_a_coarse_gain === 4'hf, "gain held");
	endtask : t_gain
	// Restart drops lock, lock returns only after the link is tracked
	task automatic t_restart;
		int n;
		n = 0;
		i_loop_restart <= 1'b1;
		cyc(2);
		chk(o_loop_lock === 1'b0, "lock cleared");
		while (o_loop_lock !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		chk(o_loop_lock === 1'b1 && n > 8, "relock");
		i_loop_restart <= 1'b0;
		cyc(2);
	endtask : t_restart
	// Range and skew settings before the first restart
	task automatic t_loop;
		i_loop_ifixed <= 3'h5;
		i_loop_delay <= 4'ha;
		i_loop_cfg_load <= 1'b1;
		cyc(1);
		i_loop_cfg_load <= 1'b0;
		cyc(2);
		chk(o_loop_ifixed === 3'h5 && o_loop_delay === 4'ha, "loop settings");
		t_restart();
		t_restart();
	endtask : t_loop
	// Watchdog, far beyond the expected run of under a thousand cycles
	initial begin
		#500000;
		bad_count++;
		results();
	end
	initial begin
		cyc(3);
		i_reset <= 1'b0;
		i_link_reset <= 1'b0;
		cyc(1);
		chk(o_chan_a_fs_mult === 5'h10 && o_chan_b_coarse_gain === 4'hf, "gain reset");
		chk(o_loop_lock === 1'b0 && o_sample === 16'h8000, "reset outputs");
		t_gated();
		t_pass();
		t_soft();
		t_gain();
		t_loop();
		results();
	end
endmodule : lsdgc_tb_top
